// *** verilog/sar_frame_cfg.svh ***
`ifndef SAR_FRAME_CFG_SVH
`define SAR_FRAME_CFG_SVH

// Converter resolution and the serial frame built around it.
`define RES_BITS        10
`define LEAD_ZEROS      2
`define FRAME_BITS      12

// Falling-edge numbers within a frame, counted from one.
`define CONV_LAST_EDGE  10
`define PU_CAL_COMMIT   16
`define NORM_CAL_START  16
`define NORM_CAL_COMMIT 32

// Edge counter width and its saturation value.
`define CNT_W           6
`define CNT_MAX         6'h3F

// First trial code of every successive-approximation search, code ceiling and offset reset value.
`define TRIAL_RESET     10'h200
`define CODE_MAX        10'h3FF
`define OCR_RESET       10'h000

// Crossing into the system clock domain.
`define SYNC_STAGES     3
`define XDOM_W          3
`define XDOM_RESET      3'h4

`endif

// *** verilog/sar_frame_pkg.sv ***
package sar_frame_pkg;

  typedef logic [9:0] code_t;

  typedef enum logic {
    MODE_CONVERT,
    MODE_POWERUP_CAL
  } frame_mode_t;

  typedef enum logic [1:0] {
    PH_OFF,
    PH_CONVERT,
    PH_QUIET,
    PH_CALIBRATE
  } phase_t;

endpackage : sar_frame_pkg

// *** verilog/xdom_if.sv ***
`timescale 1ns/10ps

interface xdom_if #(
  parameter int W = 3
);
  logic [W-1:0] raw;
  logic [W-1:0] stable;

  modport src
  (
    output raw,
    input  stable
  );

  modport dst
  (
    input  raw,
    output stable
  );
endinterface : xdom_if

// *** verilog/level_sync3.sv ***
`timescale 1ns/10ps
`include "sar_frame_cfg.svh"

module level_sync3 #(
  parameter int         W         = 3,
  parameter logic [2:0] RESET_VAL = 3'h0
)
(
  // System clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Raw levels in, filtered levels out.
  xdom_if.dst      port
);

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic [`SYNC_STAGES-1:0] stage_r;
      logic                    stable_r;

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          stage_r <= {`SYNC_STAGES{RESET_VAL[gi]}};
        end
        else
        begin
          stage_r <= {stage_r[`SYNC_STAGES-2:0], port.raw[gi]};
        end
      end

      // The first stage is never looked at; a change is taken only once the
      // second and third stages agree, which filters a single metastable bit.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          stable_r <= RESET_VAL[gi];
        end
        else if (stage_r[1] == stage_r[2])
        begin
          stable_r <= stage_r[2];
        end
      end

      assign port.stable[gi] = stable_r;
    end
  endgenerate

endmodule : level_sync3

// *** verilog/sar_adc_serial_frame.sv ***
// Operation
// - Chip-select fall holds input pair, starts conversion.
// - Conversion and shifting step on host serial clock.
// - Inputs disconnected from sampler while converting.
// - After conversion, reconnect capacitors and acquire.
// - Host triggers offset calibration, power-up or later.
// - Frame is two zeros then ten result bits.
// - First zero at select fall, rest on falls.
// - Low after twelve clocks, released on select rise.
// - Power-up calibration needs sixteen falls, else kept; the code spends it on the first frame, however short.
`timescale 1ns/10ps
`include "sar_frame_cfg.svh"

module sar_adc_serial_frame
  import sar_frame_pkg::*;
(
  // System clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial link driven by the host.
  input  wire logic       sclk,
  input  wire logic       cs_n,
  output logic            sdo_o,
  output logic            sdo_oe,
  // Analog front end control.
  input  wire logic       comp_hi,
  output logic            sample_connect,
  output logic            cal_short,
  output code_t           dac_code,
  // System-side view of results.
  output code_t           sample_word,
  output logic            sample_valid,
  output logic            cal_done,
  output logic            cal_ok,
  output logic            frame_busy
);

  // Frame logic is cleared whenever the host ends a frame, so every frame
  // starts from a known point even though the serial clock stops between
  // frames.
  logic                   frame_clr;

  logic [`CNT_W-1:0]      fall_cnt_r;
  logic [`CNT_W-1:0]      edge_num;
  frame_mode_t            mode_r;
  frame_mode_t            mode_now;
  phase_t                 phase;
  code_t                  trial_r;
  code_t                  trial_nxt;
  code_t                  res_r;
  logic                   sdo_r;
  logic                   sdo_nxt;

  logic                   step_en;
  logic [3:0]             step_bit;
  logic                   conv_last;
  logic                   cal_commit;

  // State that must survive between frames, reset only at power-up.
  logic                   pu_pending_r;
  code_t                  ocr_r;
  code_t                  conv_word_r;
  logic                   conv_tgl_r;
  logic                   cal_tgl_r;

  logic [10:0]            dac_sum;

  assign frame_clr = cs_n | rst;
  assign edge_num  = (fall_cnt_r == `CNT_MAX) ? fall_cnt_r : fall_cnt_r + 6'h01;

  // The power-up frame is known before the first serial edge arrives.
  assign mode_now  = (fall_cnt_r == 6'h00)
                   ? (pu_pending_r ? MODE_POWERUP_CAL : MODE_CONVERT)
                   : mode_r;

  // Phase of the frame, from the falls already seen.
  always_comb
  begin
    phase = PH_OFF;
    if (!cs_n)
    begin
      case (mode_now)
        MODE_POWERUP_CAL:
        begin
          if (fall_cnt_r < 6'(`PU_CAL_COMMIT))
            phase = PH_CALIBRATE;
          else
            phase = PH_QUIET;
        end
        MODE_CONVERT:
        begin
          if (fall_cnt_r < 6'(`CONV_LAST_EDGE))
            phase = PH_CONVERT;
          else if (fall_cnt_r >= 6'(`NORM_CAL_START) && fall_cnt_r < 6'(`NORM_CAL_COMMIT))
            phase = PH_CALIBRATE;
          else
            phase = PH_QUIET;
        end
        default:
        begin
          phase = PH_OFF;
        end
      endcase
    end
  end

  // The hold switch opens on the select fall itself, not on a later edge,
  // so the sample is the input at that instant.
  assign sample_connect = (phase != PH_CONVERT) && (phase != PH_CALIBRATE);
  assign cal_short      = (phase == PH_CALIBRATE);

  // Conversions compare against trial plus stored offset, which corrects
  // the code bit by bit and keeps zero latency; calibration uses the bare
  // trial so it measures the raw offset.
  assign dac_sum  = {1'b0, trial_r} + {1'b0, ocr_r};
  assign dac_code = (phase == PH_CALIBRATE) ? trial_r
                  : (dac_sum[10] ? `CODE_MAX : dac_sum[9:0]);

  // Which falling edge makes a search decision, and for which bit.
  always_comb
  begin
    step_en    = 1'b0;
    step_bit   = 4'h0;
    conv_last  = 1'b0;
    cal_commit = 1'b0;
    if (mode_now == MODE_POWERUP_CAL)
    begin
      if (edge_num <= 6'(`RES_BITS))
      begin
        step_en  = 1'b1;
        step_bit = 4'(`RES_BITS - 32'(edge_num));
      end
      cal_commit = (edge_num == 6'(`PU_CAL_COMMIT));
    end
    else
    begin
      if (edge_num <= 6'(`CONV_LAST_EDGE))
      begin
        step_en   = 1'b1;
        step_bit  = 4'(`RES_BITS - 32'(edge_num));
        conv_last = (edge_num == 6'(`CONV_LAST_EDGE));
      end
      else if (edge_num > 6'(`NORM_CAL_START) && edge_num <= 6'(`NORM_CAL_START + `RES_BITS))
      begin
        step_en  = 1'b1;
        step_bit = 4'(`NORM_CAL_START + `RES_BITS - 32'(edge_num));
      end
      cal_commit = (edge_num == 6'(`NORM_CAL_COMMIT));
    end
  end

  // One successive-approximation step: keep or drop the bit under test and
  // raise the next one.
  always_comb
  begin
    trial_nxt = trial_r;
    if (step_en)
    begin
      trial_nxt[step_bit] = comp_hi;
      if (step_bit != 4'h0)
        trial_nxt[step_bit - 4'h1] = 1'b1;
    end
    // A finished conversion rearms the search for a following calibration.
    if (conv_last)
      trial_nxt = `TRIAL_RESET;
  end

  // Serial bit launched on this falling edge.
  always_comb
  begin
    sdo_nxt = 1'b0;
    if (mode_now == MODE_CONVERT &&
        edge_num >= 6'(`LEAD_ZEROS) && edge_num < 6'(`FRAME_BITS))
    begin
      sdo_nxt = res_r[4'(`FRAME_BITS - 1 - 32'(edge_num))];
    end
  end

  always_ff @(negedge sclk or posedge frame_clr)
  begin
    if (frame_clr)
      fall_cnt_r <= 6'h00;
    else if (fall_cnt_r != `CNT_MAX)
      fall_cnt_r <= fall_cnt_r + 6'h01;
  end

  always_ff @(negedge sclk or posedge frame_clr)
  begin
    if (frame_clr)
      mode_r <= MODE_CONVERT;
    else
      mode_r <= mode_now;
  end

  always_ff @(negedge sclk or posedge frame_clr)
  begin
    if (frame_clr)
      trial_r <= `TRIAL_RESET;
    else
      trial_r <= trial_nxt;
  end

  always_ff @(negedge sclk or posedge frame_clr)
  begin
    if (frame_clr)
      res_r <= 10'h000;
    else if (step_en && mode_now == MODE_CONVERT && edge_num <= 6'(`CONV_LAST_EDGE))
      res_r[step_bit] <= comp_hi;
  end

  // Cleared while select is high, so the first zero is already present
  // when select falls; the pin is released by the enable below.
  always_ff @(negedge sclk or posedge frame_clr)
  begin
    if (frame_clr)
      sdo_r <= 1'b0;
    else
      sdo_r <= sdo_nxt;
  end

  assign sdo_o  = sdo_r;
  assign sdo_oe = !cs_n && !rst;

  // The power-up frame is consumed on its first edge even if it proves too
  // short; a short frame simply leaves the offset at its reset value.
  always_ff @(negedge sclk or posedge rst)
  begin
    if (rst)
      pu_pending_r <= 1'b1;
    else if (!cs_n)
      pu_pending_r <= 1'b0;
  end

  always_ff @(negedge sclk or posedge rst)
  begin
    if (rst)
      ocr_r <= `OCR_RESET;
    else if (!cs_n && cal_commit)
      ocr_r <= trial_r;
  end

  always_ff @(negedge sclk or posedge rst)
  begin
    if (rst)
      cal_tgl_r <= 1'b0;
    else if (!cs_n && cal_commit)
      cal_tgl_r <= ~cal_tgl_r;
  end

  // The word is frozen on the same edge as its toggle and stays put until
  // the next conversion, which is far beyond the synchroniser delay.
  always_ff @(negedge sclk or posedge rst)
  begin
    if (rst)
    begin
      conv_word_r <= 10'h000;
      conv_tgl_r  <= 1'b0;
    end
    else if (!cs_n && conv_last)
    begin
      conv_word_r <= trial_nxt == `TRIAL_RESET ? {res_r[9:1], comp_hi} : res_r;
      conv_tgl_r  <= ~conv_tgl_r;
    end
  end

  // Crossing into the system clock domain.
  xdom_if #(.W(`XDOM_W)) xdom ();

  assign xdom.raw = {cs_n, cal_tgl_r, conv_tgl_r};

  level_sync3 #(
    .W         (`XDOM_W),
    .RESET_VAL (`XDOM_RESET)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .port (xdom.dst)
  );

  logic                   conv_seen_r;
  logic                   cal_seen_r;
  code_t                  sample_word_r;
  logic                   sample_valid_r;
  logic                   cal_done_r;
  logic                   cal_ok_r;
  logic                   frame_busy_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      conv_seen_r    <= 1'b0;
      sample_word_r  <= 10'h000;
      sample_valid_r <= 1'b0;
    end
    else
    begin
      conv_seen_r    <= xdom.stable[0];
      sample_valid_r <= xdom.stable[0] ^ conv_seen_r;
      if (xdom.stable[0] ^ conv_seen_r)
        sample_word_r <= conv_word_r;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cal_seen_r <= 1'b0;
      cal_done_r <= 1'b0;
      cal_ok_r   <= 1'b0;
    end
    else
    begin
      cal_seen_r <= xdom.stable[1];
      cal_done_r <= xdom.stable[1] ^ cal_seen_r;
      if (xdom.stable[1] ^ cal_seen_r)
        cal_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      frame_busy_r <= 1'b0;
    else
      frame_busy_r <= ~xdom.stable[2];
  end

  assign sample_word  = sample_word_r;
  assign sample_valid = sample_valid_r;
  assign cal_done     = cal_done_r;
  assign cal_ok       = cal_ok_r;
  assign frame_busy   = frame_busy_r;

endmodule : sar_adc_serial_frame

// *** verification/sar_host_model.sv ***
`timescale 1ns/10ps

module sar_host_model
(
  // Serial link as the host drives it.
  output logic             sclk,
  output logic             cs_n,
  input  wire logic        sdo_o,
  input  wire logic        sdo_oe,
  // Ideal comparator behind the input pair.
  output logic             comp_hi,
  input  wire logic        sample_connect,
  input  wire logic        cal_short,
  input  wire logic [9:0]  dac_code
);
  logic [9:0] vin;
  logic [9:0] held;
  logic [9:0] cal_in;
  wire        sdo_pin = sdo_oe ? sdo_o : 1'bz;

  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    vin = 10'h000;
    held = 10'h000;
    cal_in = 10'h000;
  end

  // The sampler follows the pins only while connected, so late input moves stay unseen.
  always @(vin or sample_connect)
    if (sample_connect === 1'b1)
      held = vin;

  // Shorted inputs during calibration show the converter its own offset.
  assign comp_hi = cal_short ? (cal_in >= dac_code) : (held >= dac_code);

  // The serial clock stands high between frames and runs at 48 ns inside them.
  task automatic frame(input int n, input logic [9:0] v, input logic [9:0] off,
                       output logic [11:0] bits, output logic late_hi);
    vin = v;
    cal_in = off;
    bits = 12'h000;
    late_hi = 1'b0;
    #1 cs_n = 1'b0;
    #12;
    for (int i = 1; i <= n; i++)
    begin
      if (i <= 12)
        bits[12 - i] = sdo_pin;
      else if (sdo_pin !== 1'b0)
        late_hi = 1'b1;
      sclk = 1'b0;
      #24;
      if (i == 5)
        vin = ~v;
      sclk = 1'b1;
      #24;
    end
    #10 cs_n = 1'b1;
    #40;
  endtask : frame
endmodule : sar_host_model

// *** verification/sar_adc_serial_frame_properties.sv ***
`timescale 1ns/10ps

module sar_adc_serial_frame_properties
  import sar_frame_pkg::*;
(
  // Both clock domains.
  input wire logic  clk,
  input wire logic  rst,
  input wire logic  sclk,
  input wire logic  cs_n,
  // Link and front end.
  input wire logic  sdo_o,
  input wire logic  sdo_oe,
  input wire logic  sample_connect,
  input wire logic  cal_short,
  input wire code_t dac_code,
  // System side.
  input wire code_t sample_word,
  input wire logic  sample_valid,
  input wire logic  cal_done,
  input wire logic  cal_ok
);
  // Falls seen in the current frame, saturating like the design's own count.
  logic [5:0] falls_r;

  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      falls_r <= 6'h00;
    else if (falls_r != 6'h3F)
      falls_r <= falls_r + 6'h01;
  end

  AST_OE_TRACKS_SELECT: assert property (@(posedge clk) disable iff (rst) sdo_oe == !cs_n)
    else $error("output enable does not follow chip select");
  AST_IDLE_LOW: assert property (@(posedge clk) disable iff (rst) cs_n |-> !sdo_o)
    else $error("serial data high outside a frame");
  AST_OPEN_FRAME: assert property (@(posedge clk) disable iff (rst)
    $fell(cs_n) |-> !sdo_o && !sample_connect)
    else $error("frame opened without first zero or with inputs connected");
  AST_SECOND_ZERO: assert property (@(negedge sclk) disable iff (rst || cs_n)
    falls_r == 6'h01 |-> !sdo_o)
    else $error("second frame bit not zero");
  AST_TAIL_LOW: assert property (@(negedge sclk) disable iff (rst || cs_n)
    falls_r >= 6'h0C |-> !sdo_o)
    else $error("serial data high after twelve falls");
  AST_HELD_IN_CONV: assert property (@(negedge sclk) disable iff (rst || cs_n)
    falls_r inside {[6'h01:6'h09]} |-> !sample_connect)
    else $error("inputs connected during conversion");
  AST_ACQUIRE_AFTER: assert property (@(negedge sclk) disable iff (rst || cs_n)
    falls_r inside {[6'h0A:6'h0F]} && !cal_short |-> sample_connect)
    else $error("inputs not reconnected after conversion");
  AST_CAL_TRIAL: assert property (@(negedge sclk) disable iff (rst || cs_n)
    falls_r == 6'h10 && cal_short |-> dac_code == 10'h200)
    else $error("calibration search does not start at mid code");
  AST_VALID_PULSE: assert property (@(posedge clk) disable iff (rst)
    sample_valid |=> !sample_valid)
    else $error("result pulse longer than one cycle");
  AST_WORD_STILL: assert property (@(posedge clk) disable iff (rst)
    !sample_valid |-> $stable(sample_word))
    else $error("result word changed without a pulse");
  AST_CAL_KEPT: assert property (@(posedge clk) disable iff (rst)
    cal_done |=> cal_ok && !cal_done)
    else $error("calibration commit not recorded");
endmodule : sar_adc_serial_frame_properties

bind sar_adc_serial_frame sar_adc_serial_frame_properties u_props
(
  .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
  .sample_connect(sample_connect), .cal_short(cal_short), .dac_code(dac_code),
  .sample_word(sample_word), .sample_valid(sample_valid), .cal_done(cal_done),
  .cal_ok(cal_ok)
);

// *** verification/test_sar_adc_serial_frame.sv ***
`timescale 1ns/10ps

module test_sar_adc_serial_frame;
  logic       clk, rst, sclk, cs_n, comp_hi, sdo_o, sdo_oe, sample_connect, cal_short;
  logic       sample_valid, cal_done, cal_ok, frame_busy;
  logic [9:0] dac_code, sample_word;
  int         failures, compares, cycles, valids, cals, busys;

  sar_adc_serial_frame u_dut
  (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .comp_hi(comp_hi), .sample_connect(sample_connect), .cal_short(cal_short),
    .dac_code(dac_code), .sample_word(sample_word), .sample_valid(sample_valid),
    .cal_done(cal_done), .cal_ok(cal_ok), .frame_busy(frame_busy)
  );

  sar_host_model u_host
  (
    .sclk(sclk), .cs_n(cs_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .comp_hi(comp_hi),
    .sample_connect(sample_connect), .cal_short(cal_short), .dac_code(dac_code)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Counts pulses and cuts a hang short; a full run needs under 2000 cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (sample_valid === 1'b1)
      valids++;
    if (cal_done === 1'b1)
      cals++;
    if (frame_busy === 1'b1)
      busys++;
    if (cycles == 5000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Largest code whose offset-adjusted trial stays at or below the held input.
  function automatic logic [11:0] exp_word(input int v, input int off);
    for (int c = 1023; c > 0; c--)
      if ((c + off > 1023 ? 1023 : c + off) <= v)
        return 12'(c);
    return 12'h000;
  endfunction : exp_word

  task automatic run(input int n, input logic [9:0] v, input logic [9:0] off,
                     input logic [11:0] exp_bits, input int dv, input int dc);
    logic [11:0] bits;
    logic        late_hi;
    int          v0;
    int          c0;
    int          b0;
    v0 = valids;
    c0 = cals;
    b0 = busys;
    u_host.frame(n, v, off, bits, late_hi);
    repeat (10) @(posedge clk);
    chk("frame bits", bits, exp_bits);
    chk("late high", {11'h000, late_hi}, 12'h000);
    chk("results", 12'(valids - v0), 12'(dv));
    chk("calibrations", 12'(cals - c0), 12'(dc));
    chk("busy seen", 12'(busys > b0), 12'h001);
    chk("busy idle", {11'h000, frame_busy}, 12'h000);
    if (dv > 0)
      chk("word", {2'b00, sample_word}, exp_bits);
  endtask : run

  task automatic do_reset();
    logic [11:0] rst_seen;
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst_seen = {sdo_oe, sdo_o, sample_valid, cal_done, cal_ok, sample_connect, cal_short,
                frame_busy, 4'h0};
    chk("reset outputs", rst_seen, 12'h040);
    chk("reset word", {2'b00, sample_word}, 12'h000);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_reset

  // A short first frame spends the power-up calibration without changing the offset.
  task automatic t_powerup_short();
    run(10, 10'h155, 10'h005, 12'h000, 0, 0);
    run(12, 10'h2A7, 10'h005, 12'h2A7, 1, 0);
    chk("cal flag", {11'h000, cal_ok}, 12'h000);
    $display("test powerup_short done");
  endtask : t_powerup_short

  task automatic t_powerup_cal();
    do_reset();
    run(16, 10'h155, 10'h005, 12'h000, 0, 1);
    chk("cal flag", {11'h000, cal_ok}, 12'h001);
    $display("test powerup_cal done");
  endtask : t_powerup_cal

  task automatic t_convert();
    logic [9:0] vals [5] = '{10'h2A7, 10'h3FF, 10'h003, 10'h200, 10'h000};
    for (int i = 0; i < 5; i++)
      run(12 + 2 * (i % 2), vals[i], 10'h005, exp_word(vals[i], 5), 1, 0);
    $display("test convert done");
  endtask : t_convert

  // The 20-fall frame must leave the offset at 9, not take 2.
  task automatic t_op_cal();
    run(32, 10'h100, 10'h009, exp_word(10'h100, 5), 1, 1);
    run(12, 10'h100, 10'h002, exp_word(10'h100, 9), 1, 0);
    run(20, 10'h300, 10'h002, exp_word(10'h300, 9), 1, 0);
    run(12, 10'h300, 10'h002, exp_word(10'h300, 9), 1, 0);
    $display("test op_cal done");
  endtask : t_op_cal

  initial
  begin
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_powerup_short();
    t_powerup_cal();
    t_convert();
    t_op_cal();
    wrap_up();
  end
endmodule : test_sar_adc_serial_frame
